// file: rtl/csoir_pkg.sv
/*
  Shared constants and types of the core status, option and interrupt
  register group: register addresses, bit positions, reset values and
  the encoding of the flag operations that the processor core requests.
  Assumes an 8-bit data path and an 8-bit direct data address.
*/
package csoir_pkg;

  // full direct addresses of the registers (bank bit in bit 7)
  localparam logic [7:0] CSOIR_ADDR_STATUS = 8'h03;
  localparam logic [7:0] CSOIR_ADDR_INTCTL = 8'h0b;
  localparam logic [7:0] CSOIR_ADDR_OPTION = 8'h81;
  localparam logic [7:0] CSOIR_ADDR_PIEN = 8'h8c;
  // registers mirrored in both banks match on the low seven bits
  localparam logic [6:0] CSOIR_LOW_STATUS = 7'h03;
  localparam logic [6:0] CSOIR_LOW_INTCTL = 7'h0b;

  // core_status bit positions
  localparam int CSOIR_ST_IRP = 7;
  localparam int CSOIR_ST_RP1 = 6;
  localparam int CSOIR_ST_BANK = 5;
  localparam int CSOIR_ST_TO_N = 4;
  localparam int CSOIR_ST_PD_N = 3;
  localparam int CSOIR_ST_Z = 2;
  localparam int CSOIR_ST_DC = 1;
  localparam int CSOIR_ST_C = 0;

  // timer_prescale_options bit positions
  localparam int CSOIR_OP_PU_DIS_N = 7;
  localparam int CSOIR_OP_IRQ_EDGE = 6;
  localparam int CSOIR_OP_T0_SRC = 5;
  localparam int CSOIR_OP_T0_EDGE = 4;
  localparam int CSOIR_OP_PS_OWNER = 3;
  localparam int CSOIR_OP_RATE_HI = 2;

  // interrupt_control bit positions
  localparam int CSOIR_IC_GIE = 7;
  localparam int CSOIR_IC_PERIPH_IRQ_EN = 6;
  localparam int CSOIR_IC_T0_EN = 5;
  localparam int CSOIR_IC_EXT_EN = 4;
  localparam int CSOIR_IC_PC_EN = 3;
  localparam int CSOIR_IC_T0_FLAG = 2;
  localparam int CSOIR_IC_EXT_FLAG = 1;
  localparam int CSOIR_IC_PC_FLAG = 0;

  // implemented bits of peripheral_irq_enable
  localparam logic [7:0] CSOIR_PIEN_MASK = 8'hc9;

  // values after reset
  localparam logic [7:0] CSOIR_RST_STATUS = 8'h18;
  localparam logic [7:0] CSOIR_RST_OPTION = 8'hff;
  localparam logic [7:0] CSOIR_RST_INTCTL = 8'h00;
  localparam logic [7:0] CSOIR_RST_PIEN = 8'h00;
  localparam logic [7:0] CSOIR_RST_PSCNT = 8'h00;

  // flag operations requested by the core for one instruction
  typedef enum logic [2:0] {
    CSOIR_FOP_NONE = 3'h0,
    CSOIR_FOP_ADD = 3'h1,
    CSOIR_FOP_SUB = 3'h2,
    CSOIR_FOP_LOGIC = 3'h3,
    CSOIR_FOP_ROTL = 3'h4,
    CSOIR_FOP_ROTR = 3'h5
  } csoir_fop_t;

endpackage

// file: rtl/csoir_pin_edge.sv
/*
  Synchroniser and edge detector for a group of asynchronous pins.
  Each pin passes two flip-flops, a third stage holds the previous
  synchronised level. Assumes pins may change at any time.
*/
`timescale 1ns/1ns
module csoir_pin_edge #(
  parameter int WIDTH = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [WIDTH-1:0] i_pins,
  output logic [WIDTH-1:0] o_level,
  output logic [WIDTH-1:0] o_rise,
  output logic [WIDTH-1:0] o_fall
);

  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] sync;
  logic [WIDTH-1:0] prev;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_pin
      always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
          meta[gi] <= 1'b0;
          sync[gi] <= 1'b0;
          prev[gi] <= 1'b0;
        end else begin
          meta[gi] <= i_pins[gi];
          sync[gi] <= meta[gi];
          prev[gi] <= sync[gi];
        end
      end
      assign o_rise[gi] = sync[gi] & ~prev[gi];
      assign o_fall[gi] = ~sync[gi] & prev[gi];
    end
  endgenerate

  assign o_level = sync;

endmodule

// file: rtl/csoir_regs.sv
/*
  Core status, option and interrupt register group of a small 8-bit
  controller: status with bank select and arithmetic flags, options for
  the shared prescaler and timer source, interrupt control and the
  peripheral interrupt enables, plus the interrupt request.
  Assumes the core presents one operand access per cycle on the
  instruction clock and that peripherals give one-cycle event pulses.
*/
`timescale 1ns/1ns
module csoir_regs
  import csoir_pkg::*;
#(
  parameter int PORT_W = 6
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // operand access from the core
  input wire logic [6:0] i_file_addr,
  input wire logic i_wr_en,
  input wire logic [7:0] i_wr_data,
  input wire logic i_rd_en,
  output logic [7:0] o_rd_data,
  output logic [7:0] o_data_addr,
  output logic o_bank_select,
  // flag update of the executing instruction
  input wire csoir_fop_t i_flag_op,
  input wire logic [7:0] i_alu_a,
  input wire logic [7:0] i_alu_b,
  // reset-status events
  input wire logic i_kick_op,
  input wire logic i_sleep_op,
  input wire logic i_watchdog_timeout,
  // timer and prescaler
  input wire logic i_instr_cycle_tick,
  input wire logic i_watchdog_base_tick,
  input wire logic i_timer_zero_rollover,
  output logic o_timer_zero_inc,
  output logic o_watchdog_tick,
  // pins and pull-ups
  input wire logic i_external_irq_pin,
  input wire logic i_external_timer_clock_pin,
  input wire logic [PORT_W-1:0] i_port_pins,
  input wire logic [PORT_W-1:0] i_pin_change_en_mask,
  input wire logic [PORT_W-1:0] i_pullup_latch,
  output logic [PORT_W-1:0] o_pullup_en,
  // peripheral flags and the request
  input wire logic [7:0] i_peripheral_flag_reg,
  output logic o_irq
);

  //////////////////////////////////////////////////////////////////////
  // state

  logic [7:0] core_status;
  logic [7:0] timer_prescale_options;
  logic [7:0] interrupt_control;
  logic [7:0] peripheral_irq_enable;
  logic [7:0] prescale_count;

  logic [7:0] full_addr;
  logic hit_status;
  logic hit_intctl;
  logic hit_option;
  logic hit_pien;

  logic [PORT_W+1:0] pin_level;
  logic [PORT_W+1:0] pin_rise;
  logic [PORT_W+1:0] pin_fall;
  logic ext_irq_edge;
  logic ext_clk_edge;
  logic port_changed;

  logic [8:0] sum_full;
  logic [4:0] sum_low;
  logic next_z;
  logic next_dc;
  logic next_c;
  logic upd_z;
  logic upd_dc_c;

  logic [2:0] rate;
  logic owner_wdt;
  logic timer_src_tick;
  logic ps_tick;
  logic [7:0] ps_mask;
  logic ps_out;

  logic set_t0;
  logic set_ext;
  logic set_pc;
  logic core_pend;
  logic periph_pend;

  //////////////////////////////////////////////////////////////////////
  // address decode

  assign full_addr = {core_status[CSOIR_ST_BANK], i_file_addr};
  assign o_data_addr = full_addr;
  assign o_bank_select = core_status[CSOIR_ST_BANK];
  assign hit_status = (i_file_addr == CSOIR_LOW_STATUS);
  assign hit_intctl = (i_file_addr == CSOIR_LOW_INTCTL);
  assign hit_option = (full_addr == CSOIR_ADDR_OPTION);
  assign hit_pien = (full_addr == CSOIR_ADDR_PIEN);

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers: port pins, external irq pin, timer clock pin

  csoir_pin_edge #(
    .WIDTH(PORT_W + 2)
  ) u_pin_edge (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_pins({i_external_timer_clock_pin, i_external_irq_pin,
             i_port_pins}),
    .o_level(pin_level),
    .o_rise(pin_rise),
    .o_fall(pin_fall)
  );

  assign ext_irq_edge = timer_prescale_options[CSOIR_OP_IRQ_EDGE] ?
                        pin_rise[PORT_W] : pin_fall[PORT_W];
  assign ext_clk_edge = timer_prescale_options[CSOIR_OP_T0_EDGE] ?
                        pin_fall[PORT_W+1] : pin_rise[PORT_W+1];
  assign port_changed = |((pin_rise[PORT_W-1:0] | pin_fall[PORT_W-1:0])
                          & i_pin_change_en_mask);

  //////////////////////////////////////////////////////////////////////
  // arithmetic flags

  always_comb begin
    sum_full = 9'h000;
    sum_low = 5'h00;
    next_z = core_status[CSOIR_ST_Z];
    next_dc = core_status[CSOIR_ST_DC];
    next_c = core_status[CSOIR_ST_C];
    upd_z = 1'b0;
    upd_dc_c = 1'b0;
    case (i_flag_op)
      CSOIR_FOP_ADD: begin
        sum_full = {1'b0, i_alu_a} + {1'b0, i_alu_b};
        sum_low = {1'b0, i_alu_a[3:0]} + {1'b0, i_alu_b[3:0]};
        next_z = (sum_full[7:0] == 8'h00);
        next_dc = sum_low[4];
        next_c = sum_full[8];
        upd_z = 1'b1;
        upd_dc_c = 1'b1;
      end
      CSOIR_FOP_SUB: begin
        // subtract by adding two's complement: carry is inverted borrow
        sum_full = {1'b0, i_alu_a} + {1'b0, ~i_alu_b} + 9'h001;
        sum_low = {1'b0, i_alu_a[3:0]} + {1'b0, ~i_alu_b[3:0]}
                  + 5'h01;
        next_z = (sum_full[7:0] == 8'h00);
        next_dc = sum_low[4];
        next_c = sum_full[8];
        upd_z = 1'b1;
        upd_dc_c = 1'b1;
      end
      CSOIR_FOP_LOGIC: begin
        // operand a carries the logic result
        next_z = (i_alu_a == 8'h00);
        upd_z = 1'b1;
      end
      CSOIR_FOP_ROTL: begin
        next_c = i_alu_a[7];
        upd_dc_c = 1'b1;
      end
      CSOIR_FOP_ROTR: begin
        next_c = i_alu_a[0];
        upd_dc_c = 1'b1;
      end
      default: begin
        upd_z = 1'b0;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////
  // core_status

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      core_status <= CSOIR_RST_STATUS;
    end else begin
      if (i_wr_en && hit_status) begin
        // reserved upper bits stored as written, not used
        core_status[CSOIR_ST_IRP] <= i_wr_data[CSOIR_ST_IRP];
        core_status[CSOIR_ST_RP1] <= i_wr_data[CSOIR_ST_RP1];
        core_status[CSOIR_ST_BANK] <= i_wr_data[CSOIR_ST_BANK];
        if (!upd_z) begin
          core_status[CSOIR_ST_Z] <= i_wr_data[CSOIR_ST_Z];
        end
        if (!upd_dc_c) begin
          core_status[CSOIR_ST_DC] <= i_wr_data[CSOIR_ST_DC];
          core_status[CSOIR_ST_C] <= i_wr_data[CSOIR_ST_C];
        end
      end
      if (upd_z) begin
        core_status[CSOIR_ST_Z] <= next_z;
      end
      if (upd_dc_c) begin
        core_status[CSOIR_ST_DC] <= next_dc;
        core_status[CSOIR_ST_C] <= next_c;
      end
      // timeout and power-down move only on their events
      if (i_watchdog_timeout) begin
        core_status[CSOIR_ST_TO_N] <= 1'b0;
      end else if (i_kick_op || i_sleep_op) begin
        core_status[CSOIR_ST_TO_N] <= 1'b1;
      end
      if (i_kick_op) begin
        core_status[CSOIR_ST_PD_N] <= 1'b1;
      end else if (i_sleep_op) begin
        core_status[CSOIR_ST_PD_N] <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // timer_prescale_options

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      timer_prescale_options <= CSOIR_RST_OPTION;
    end else if (i_wr_en && hit_option) begin
      timer_prescale_options <= i_wr_data;
    end
  end

  assign o_pullup_en = timer_prescale_options[CSOIR_OP_PU_DIS_N] ?
                       {PORT_W{1'b0}} : i_pullup_latch;

  //////////////////////////////////////////////////////////////////////
  // shared prescaler

  assign rate = timer_prescale_options[CSOIR_OP_RATE_HI:0];
  assign owner_wdt = timer_prescale_options[CSOIR_OP_PS_OWNER];
  assign timer_src_tick = timer_prescale_options[CSOIR_OP_T0_SRC] ?
                          ext_clk_edge : i_instr_cycle_tick;
  assign ps_tick = owner_wdt ? i_watchdog_base_tick : timer_src_tick;
  // low k bits all ones means 2^k ticks counted
  assign ps_mask = owner_wdt ? ((8'h01 << rate) - 8'h01)
                             : ((8'h02 << rate) - 8'h01);
  assign ps_out = ps_tick && ((prescale_count & ps_mask) == ps_mask);

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prescale_count <= CSOIR_RST_PSCNT;
    end else if (i_wr_en && hit_option
                 && (i_wr_data[CSOIR_OP_PS_OWNER] != owner_wdt)) begin
      // restart division when the prescaler changes owner
      prescale_count <= CSOIR_RST_PSCNT;
    end else if (ps_tick) begin
      prescale_count <= prescale_count + 8'h01;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_timer_zero_inc <= 1'b0;
      o_watchdog_tick <= 1'b0;
    end else begin
      o_timer_zero_inc <= owner_wdt ? timer_src_tick : ps_out;
      o_watchdog_tick <= owner_wdt ? ps_out : i_watchdog_base_tick;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // interrupt_control

  assign set_t0 = i_timer_zero_rollover;
  assign set_ext = ext_irq_edge;
  assign set_pc = port_changed;

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      interrupt_control <= CSOIR_RST_INTCTL;
    end else begin
      if (i_wr_en && hit_intctl) begin
        interrupt_control <= i_wr_data;
      end
      // events win over a same-cycle software clear
      if (set_t0) begin
        interrupt_control[CSOIR_IC_T0_FLAG] <= 1'b1;
      end
      if (set_ext) begin
        interrupt_control[CSOIR_IC_EXT_FLAG] <= 1'b1;
      end
      if (set_pc) begin
        interrupt_control[CSOIR_IC_PC_FLAG] <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // peripheral_irq_enable

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      peripheral_irq_enable <= CSOIR_RST_PIEN;
    end else if (i_wr_en && hit_pien) begin
      peripheral_irq_enable <= i_wr_data & CSOIR_PIEN_MASK;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // interrupt request

  assign core_pend =
    (interrupt_control[CSOIR_IC_T0_EN] &
     interrupt_control[CSOIR_IC_T0_FLAG]) |
    (interrupt_control[CSOIR_IC_EXT_EN] &
     interrupt_control[CSOIR_IC_EXT_FLAG]) |
    (interrupt_control[CSOIR_IC_PC_EN] &
     interrupt_control[CSOIR_IC_PC_FLAG]);
  assign periph_pend = interrupt_control[CSOIR_IC_PERIPH_IRQ_EN] &
    (|(peripheral_irq_enable & i_peripheral_flag_reg
       & CSOIR_PIEN_MASK));

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= interrupt_control[CSOIR_IC_GIE]
               & (core_pend | periph_pend);
    end
  end

  //////////////////////////////////////////////////////////////////////
  // operand read

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data <= 8'h00;
    end else if (i_rd_en) begin
      if (hit_status) begin
        o_rd_data <= core_status;
      end else if (hit_intctl) begin
        o_rd_data <= interrupt_control;
      end else if (hit_option) begin
        o_rd_data <= timer_prescale_options;
      end else if (hit_pien) begin
        o_rd_data <= peripheral_irq_enable;
      end else begin
        o_rd_data <= 8'h00;
      end
    end
  end

endmodule

// file: verif/csoir_regs_assertions.sv
/*
  Port checker of the status, option and interrupt register group.
  Assumes one clock and the asynchronous active-low reset.
*/
`timescale 1ns/1ns
module csoir_regs_assertions
  import csoir_pkg::*;
#(
  parameter int PORT_W = 6
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic [6:0] i_file_addr,
  input wire logic i_wr_en,
  input wire logic [7:0] i_wr_data,
  input wire logic i_rd_en,
  input wire logic [7:0] o_rd_data,
  input wire logic [7:0] o_data_addr,
  input wire logic o_bank_select,
  input wire logic i_kick_op,
  input wire logic i_sleep_op,
  input wire logic i_watchdog_timeout,
  input wire logic i_timer_zero_rollover,
  input wire logic [PORT_W-1:0] i_pullup_latch,
  input wire logic [PORT_W-1:0] o_pullup_en,
  input wire logic o_irq
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  logic pu_dis, global_irq_en, t0_en, evt_seen;
  wire logic wr_bank = i_wr_data[CSOIR_ST_BANK];
  wire logic wr_ic = i_wr_en && i_file_addr == CSOIR_LOW_INTCTL;
  wire logic rd_st = i_rd_en && i_file_addr == CSOIR_LOW_STATUS;
  ////////////////////////////////////////////////////////////////////////
  // shadow of the pull-up disable bit
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pu_dis <= 1'b1;
    end else if (i_wr_en && o_data_addr == CSOIR_ADDR_OPTION) begin
      pu_dis <= i_wr_data[CSOIR_OP_PU_DIS_N];
    end
  end
  // shadow of the enables gating the timer request
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      global_irq_en <= 1'b0;
      t0_en <= 1'b0;
    end else if (wr_ic) begin
      global_irq_en <= i_wr_data[CSOIR_IC_GIE];
      t0_en <= i_wr_data[CSOIR_IC_T0_EN];
    end
  end
  // any event that may lower status bits 4 or 3
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      evt_seen <= 1'b0;
    end else if (i_sleep_op || i_watchdog_timeout) begin
      evt_seen <= 1'b1;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  sequence s_sleep_rd;
    i_sleep_op && !i_kick_op && !i_watchdog_timeout
    ##1 !i_kick_op && !i_watchdog_timeout ##1 rd_st;
  endsequence
  sequence s_tmo_rd;
    i_watchdog_timeout ##1 !i_kick_op && !i_sleep_op ##1 rd_st;
  endsequence
  a_bank_addr_map: assert property (
    o_data_addr == {o_bank_select, i_file_addr})
    else $error("bank bit missing from data address");
  a_bank_follows_wr: assert property (
    i_wr_en && i_file_addr == CSOIR_LOW_STATUS
    |=> o_bank_select == $past(wr_bank))
    else $error("bank select did not follow status write");
  a_pullup_gate: assert property (
    o_pullup_en == (pu_dis ? {PORT_W{1'b0}} : i_pullup_latch))
    else $error("pull-up enables wrong");
  a_irq_global_gate: assert property (!global_irq_en |=> !o_irq)
    else $error("request raised without global enable");
  a_rollover_request: assert property (
    i_timer_zero_rollover && global_irq_en && t0_en && !wr_ic |-> ##2 o_irq)
    else $error("rollover did not raise request");
  a_pien_gaps_zero: assert property (
    i_rd_en && o_data_addr == CSOIR_ADDR_PIEN
    |=> (o_rd_data & 8'h36) == 8'h00)
    else $error("unimplemented enable bits read nonzero");
  a_reset_bits_set: assert property (
    rd_st && !evt_seen |=> o_rd_data[4:3] == 2'b11)
    else $error("status bits 4 and 3 not set");
  a_sleep_bits: assert property (
    s_sleep_rd |=> o_rd_data[4:3] == 2'b10)
    else $error("sleep did not give bits 4,3 = 10");
  a_timeout_low: assert property (
    s_tmo_rd |=> !o_rd_data[CSOIR_ST_TO_N])
    else $error("timeout did not clear bit 4");
endmodule

bind csoir_regs csoir_regs_assertions #(.PORT_W(PORT_W)) u_chk (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_file_addr(i_file_addr),
  .i_wr_en(i_wr_en), .i_wr_data(i_wr_data), .i_rd_en(i_rd_en),
  .o_rd_data(o_rd_data), .o_data_addr(o_data_addr),
  .o_bank_select(o_bank_select), .i_kick_op(i_kick_op),
  .i_sleep_op(i_sleep_op), .i_watchdog_timeout(i_watchdog_timeout),
  .i_timer_zero_rollover(i_timer_zero_rollover),
  .i_pullup_latch(i_pullup_latch), .o_pullup_en(o_pullup_en), .o_irq(o_irq)
);

// file: verif/csoir_core_model.sv
/*
  Processor core model: operand accesses, flag operations, reset events.
  Assumes the register group samples on the rising clock edge.
*/
`timescale 1ns/1ns
module csoir_core_model
  import csoir_pkg::*;
(
  input wire logic i_clk_sys,
  input wire logic [7:0] i_rd_data,
  output logic [6:0] o_file_addr,
  output logic o_wr_en,
  output logic [7:0] o_wr_data,
  output logic o_rd_en,
  output csoir_fop_t o_flag_op,
  output logic [7:0] o_alu_a,
  output logic [7:0] o_alu_b,
  output logic [2:0] o_evt
);
  initial begin
    o_file_addr = 7'h00;
    o_wr_en = 1'b0;
    o_wr_data = 8'h00;
    o_rd_en = 1'b0;
    o_flag_op = CSOIR_FOP_NONE;
    o_alu_a = 8'h00;
    o_alu_b = 8'h00;
    o_evt = 3'h0;
  end
  // one instruction cycle; released address, data and operands are inverted, controls cleared
  task automatic step(input csoir_fop_t op, input logic [7:0] a, b,
      input logic [2:0] ev, input logic we, input logic [7:0] ad, d);
    o_flag_op = op;
    o_alu_a = a;
    o_alu_b = b;
    o_evt = ev;
    o_wr_en = we;
    o_file_addr = ad[6:0];
    o_wr_data = d;
    @(posedge i_clk_sys);
    #1;
    o_flag_op = CSOIR_FOP_NONE;
    o_evt = 3'h0;
    o_wr_en = 1'b0;
    o_file_addr = ~ad[6:0];
    o_wr_data = ~d;
    o_alu_a = ~a;
    o_alu_b = ~b;
    // a free edge before the next request
    @(posedge i_clk_sys);
    #1;
  endtask
  task automatic rd(input logic [6:0] ad, output logic [7:0] q);
    o_rd_en = 1'b1;
    o_file_addr = ad;
    @(posedge i_clk_sys);
    #1;
    o_rd_en = 1'b0;
    o_file_addr = ~ad;
    q = i_rd_data;
    @(posedge i_clk_sys);
    #1;
  endtask
endmodule

// file: verif/tb.sv
/*
  Self-checking bench of the register group with the core model.
  Assumes a 100 MHz clock and inputs driven 1 ns after each edge.
*/
`timescale 1ns/1ns
module tb;
  import csoir_pkg::*;
  logic clk, rst_n, wr_en, rd_en, bank, irq, tz_inc, wd_tick, cnt_on;
  logic ic_tick, wb_tick, roll, irq_pin, tck_pin;
  logic [6:0] addr;
  logic [7:0] wr_data, rd_data, data_addr, alu_a, alu_b, pflag, q;
  logic [5:0] port, mask, latch, pu_en;
  logic [2:0] evt, lo;
  csoir_fop_t fop;
  int fail_count, n_tests, tz_n, wd_n;
  csoir_fop_t ops [9] = '{CSOIR_FOP_ADD, CSOIR_FOP_ADD, CSOIR_FOP_SUB,
    CSOIR_FOP_SUB, CSOIR_FOP_LOGIC, CSOIR_FOP_ROTL, CSOIR_FOP_ROTR,
    CSOIR_FOP_LOGIC, CSOIR_FOP_NONE};
  logic [7:0] av [9] = '{8'h08, 8'h80, 8'h05, 8'h03, 8'h00, 8'h81, 8'h02,
    8'h5a, 8'h00};
  logic [7:0] bv [9] = '{8'h08, 8'h80, 8'h05, 8'h05, 8'h11, 8'h00, 8'h00,
    8'h00, 8'h00};
  logic [2:0] ev [7] = '{3'h4, 3'h1, 3'h2, 3'h4, 3'h1, 3'h5, 3'h1};
  logic [1:0] e43 [7] = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h3, 2'h1, 2'h3};
  ////////////////////////////////////////////////////////////////////////
  csoir_core_model core (.i_clk_sys(clk), .i_rd_data(rd_data),
    .o_file_addr(addr), .o_wr_en(wr_en), .o_wr_data(wr_data),
    .o_rd_en(rd_en), .o_flag_op(fop), .o_alu_a(alu_a), .o_alu_b(alu_b),
    .o_evt(evt));
  csoir_regs #(.PORT_W(6)) uut (.i_clk_sys(clk), .i_rst_n(rst_n),
    .i_file_addr(addr), .i_wr_en(wr_en), .i_wr_data(wr_data),
    .i_rd_en(rd_en), .o_rd_data(rd_data), .o_data_addr(data_addr),
    .o_bank_select(bank), .i_flag_op(fop), .i_alu_a(alu_a),
    .i_alu_b(alu_b), .i_kick_op(evt[0]), .i_sleep_op(evt[1]),
    .i_watchdog_timeout(evt[2]), .i_instr_cycle_tick(ic_tick),
    .i_watchdog_base_tick(wb_tick), .i_timer_zero_rollover(roll),
    .o_timer_zero_inc(tz_inc), .o_watchdog_tick(wd_tick),
    .i_external_irq_pin(irq_pin), .i_external_timer_clock_pin(tck_pin),
    .i_port_pins(port), .i_pin_change_en_mask(mask),
    .i_pullup_latch(latch), .o_pullup_en(pu_en),
    .i_peripheral_flag_reg(pflag), .o_irq(irq));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (cnt_on) begin
      // an unknown pulse counts as a pulse so that it shows
      tz_n <= tz_n + ((tz_inc === 1'b0) ? 0 : 1);
      wd_n <= wd_n + ((wd_tick === 1'b0) ? 0 : 1);
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    if (fail_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t value %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, exp);
    n_tests++;
    if (got != exp) begin
      fail_count++;
      $display("BAD %0t count %0d, expected %0d", $time, got, exp);
    end
  endtask
  task automatic chk_irq(input logic exp);
    int k;
    k = 0;
    while (irq !== exp && k < 8) begin
      @(posedge clk);
      #1;
      k++;
    end
    n_tests++;
    if (irq !== exp) begin
      fail_count++;
      $display("BAD %0t request not %b", $time, exp);
      complete_run();
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] ad, d);
    core.step(CSOIR_FOP_NONE, 8'h00, 8'h00, 3'h0, 1'b1, ad, d);
  endtask
  task automatic rdc(input logic [7:0] ad, exp);
    core.rd(ad[6:0], q);
    chk8(q, exp);
  endtask
  task automatic count(input int t);
    tz_n = 0;
    wd_n = 0;
    cnt_on = 1'b1;
    ic_tick = 1'b1;
    wb_tick = 1'b1;
    idle(t);
    ic_tick = 1'b0;
    wb_tick = 1'b0;
    idle(3);
    cnt_on = 1'b0;
  endtask
  // expected {zero, digit carry, carry} after one flag operation
  function automatic logic [2:0] flags(input csoir_fop_t op,
      input logic [7:0] a, b, input logic [2:0] p);
    logic [7:0] bb;
    logic [8:0] s, ci;
    logic [4:0] h;
    bb = (op == CSOIR_FOP_SUB) ? ~b : b;
    ci = (op == CSOIR_FOP_SUB) ? 9'h001 : 9'h000;
    s = {1'b0, a} + {1'b0, bb} + ci;
    h = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + ci[4:0];
    case (op)
      CSOIR_FOP_ADD, CSOIR_FOP_SUB: flags = {s[7:0] == 8'h00, h[4], s[8]};
      CSOIR_FOP_LOGIC: flags = {a == 8'h00, p[1:0]};
      CSOIR_FOP_ROTL: flags = {p[2:1], a[7]};
      CSOIR_FOP_ROTR: flags = {p[2:1], a[0]};
      default: flags = p;
    endcase
  endfunction
  task automatic pulse_roll();
    roll = 1'b1;
    idle(1);
    roll = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    fail_count++;
    complete_run();
  end
  initial begin
    rst_n = 1'b0;
    cnt_on = 1'b0;
    {ic_tick, wb_tick, roll, irq_pin, tck_pin} = 5'h00;
    port = 6'h00;
    mask = 6'h00;
    latch = 6'h2d;
    pflag = 8'h00;
    idle(10);
    rst_n = 1'b1;
    idle(1);
    rdc(8'h03, 8'h18);
    rdc(8'h0b, 8'h00);
    rdc(8'h01, 8'h00);
    chk8({2'b00, pu_en}, 8'h00);
    wr(8'h03, 8'h20);
    chk8({7'h00, bank}, 8'h01);
    rdc(8'h01, 8'hff);
    rdc(8'h03, 8'h38);
    rdc(8'h0c, 8'h00);
    wr(8'h0c, 8'hff);
    rdc(8'h0c, 8'hc9);
    for (int o = 0; o < 2; o++) begin
      for (int n = 0; n < 8; n++) begin
        wr(8'h81, 8'hc0 | 8'((1 - o) << 3) | 8'(n));
        wr(8'h81, 8'hc0 | 8'(o << 3) | 8'(n));
        count(256);
        chk_n(tz_n, (o == 1) ? 256 : 256 >> (n + 1));
        chk_n(wd_n, (o == 1) ? 256 >> n : 256);
      end
    end
    for (int m = 0; m < 2; m++) begin
      wr(8'h81, (m == 1) ? 8'hb8 : 8'ha8);
      tz_n = 0;
      cnt_on = 1'b1;
      ic_tick = 1'b1;
      tck_pin = 1'b1;
      idle(6);
      chk_n(tz_n, 1 - m);
      tck_pin = 1'b0;
      idle(6);
      chk_n(tz_n, 1);
      cnt_on = 1'b0;
      ic_tick = 1'b0;
    end
    wr(8'h81, 8'h7f);
    chk8({2'b00, pu_en}, {2'b00, latch});
    pulse_roll();
    rdc(8'h0b, 8'h04);
    wr(8'h0b, 8'ha0);
    rdc(8'h0b, 8'ha0);
    pulse_roll();
    chk_irq(1'b1);
    wr(8'h0b, 8'h24);
    idle(3);
    chk_irq(1'b0);
    wr(8'h0b, 8'ha4);
    chk_irq(1'b1);
    wr(8'h0b, 8'h90);
    irq_pin = 1'b1;
    chk_irq(1'b1);
    rdc(8'h0b, 8'h92);
    wr(8'h0b, 8'h90);
    irq_pin = 1'b0;
    idle(6);
    rdc(8'h0b, 8'h90);
    wr(8'h81, 8'h3f);
    irq_pin = 1'b1;
    idle(6);
    rdc(8'h0b, 8'h90);
    irq_pin = 1'b0;
    chk_irq(1'b1);
    wr(8'h0b, 8'h88);
    port = 6'h01;
    idle(6);
    rdc(8'h0b, 8'h88);
    mask = 6'h01;
    port = 6'h00;
    chk_irq(1'b1);
    rdc(8'h0b, 8'h89);
    pflag = 8'h06;
    wr(8'h0b, 8'hc0);
    idle(3);
    chk_irq(1'b0);
    pflag = 8'h01;
    chk_irq(1'b1);
    wr(8'h0b, 8'h80);
    idle(3);
    chk_irq(1'b0);
    wr(8'h03, 8'h00);
    lo = 3'h0;
    for (int i = 0; i < 9; i++) begin
      core.step(ops[i], av[i], bv[i], 3'h0, 1'b0, 8'h00, 8'h00);
      lo = flags(ops[i], av[i], bv[i], lo);
      rdc(8'h03, {5'b00011, lo});
    end
    core.step(CSOIR_FOP_ADD, 8'hff, 8'h01, 3'h0, 1'b1, 8'h03, 8'h00);
    rdc(8'h03, 8'h1f);
    core.step(CSOIR_FOP_LOGIC, 8'h5a, 8'h00, 3'h0, 1'b1, 8'h03, 8'h00);
    rdc(8'h03, 8'h18);
    wr(8'h03, 8'h07);
    rdc(8'h03, 8'h1f);
    for (int i = 0; i < 7; i++) begin
      core.step(CSOIR_FOP_NONE, 8'h00, 8'h00, ev[i], 1'b0, 8'h00, 8'h00);
      rdc(8'h03, {3'b000, e43[i], 3'b111});
    end
    // reset in mid-run brings back the power-up values
    rst_n = 1'b0;
    idle(2);
    rst_n = 1'b1;
    idle(1);
    rdc(8'h03, 8'h18);
    rdc(8'h0b, 8'h00);
    complete_run();
  end
endmodule
